// >>> hdl/rco_refout.v
`timescale 1ns/1ps
`default_nettype none

`include "rco_defs.vh"

module rco_refout (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire primary_osc_tick,
    input wire sys_clk_tick,
    input wire sleep_mode,
    output wire refout_pin,
    output wire refout_pin_oe,
    output wire primary_osc_power
);

    // ************************************************************
    // registers
    // ************************************************************
    reg [15:0] refout_control_reg;
    reg [1:0] sys_cfg_reg;
    reg [1:0] prim_sync_reg;
    reg [1:0] sys_sync_reg;
    reg [1:0] sleep_sync_reg;
    reg prim_last_reg;
    reg sys_last_reg;

    wire refout_output_enable = refout_control_reg[`RCO_BIT_EN];
    wire refout_run_in_sleep = refout_control_reg[`RCO_BIT_SLP];
    wire refout_source_select = refout_control_reg[`RCO_BIT_SEL];
    wire [3:0] refout_divisor = refout_control_reg[`RCO_DIV_HI:`RCO_DIV_LO];
    wire primary_osc_keep_alive = sys_cfg_reg[`RCO_SYS_KEEP];
    wire primary_mode = sys_cfg_reg[`RCO_SYS_PRIM_MODE];
    wire sleeping = sleep_sync_reg[1];
    // gate for the divider; declared here because the status read uses it
    wire run;

    // decodes a register address, used by both read and write paths
    function [1:0] reg_sel;
        input [11:0] addr;
        begin
            case (addr)
                `RCO_ADDR_CTRL: reg_sel = 2'h1;
                `RCO_ADDR_STATUS: reg_sel = 2'h2;
                `RCO_ADDR_SYS: reg_sel = 2'h3;
                default: reg_sel = 2'h0;
            endcase
        end
    endfunction

    // ************************************************************
    // apb slave, zero wait states
    // ************************************************************
    assign pready = 1'b1;
    wire access = psel && penable;
    wire [1:0] sel = reg_sel(paddr);

    // write path; reserved bits are masked so they never store
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refout_control_reg <= `RCO_CTRL_RESET;
            sys_cfg_reg <= 2'h0;
        end else if (access && pwrite) begin
            if (sel == 2'h1) begin
                if (pstrb[1]) begin
                    refout_control_reg[15:8] <= pwdata[15:8] & 8'hbf;
                end
                refout_control_reg[7:0] <= 8'h00;
            end
            if (sel == 2'h3 && pstrb[0]) begin
                sys_cfg_reg <= pwdata[1:0];
            end
        end
    end

    // read path and error answer for unmapped addresses
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= (sel == 2'h0);
            case (sel)
                2'h1: prdata <= {16'h0000, refout_control_reg};
                2'h2: prdata <= {29'h00000000, primary_osc_power, run, refout_pin};
                2'h3: prdata <= {30'h00000000, sys_cfg_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ************************************************************
    // input synchronisers for asynchronous tick and sleep inputs
    // ************************************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prim_sync_reg <= 2'h0;
            sys_sync_reg <= 2'h0;
            sleep_sync_reg <= 2'h0;
            prim_last_reg <= 1'b0;
            sys_last_reg <= 1'b0;
        end else begin
            prim_sync_reg <= {prim_sync_reg[0], primary_osc_tick};
            sys_sync_reg <= {sys_sync_reg[0], sys_clk_tick};
            sleep_sync_reg <= {sleep_sync_reg[0], sleep_mode};
            prim_last_reg <= prim_sync_reg[1];
            sys_last_reg <= sys_sync_reg[1];
        end
    end

    // ************************************************************
    // base clock choice, sleep gating and oscillator power
    // ************************************************************
    // rising edges of each source; the system tick reflects whatever
    // source the core clock currently uses, so switches carry through
    wire prim_edge = prim_sync_reg[1] & ~prim_last_reg;
    wire sys_edge = sys_sync_reg[1] & ~sys_last_reg;
    // code zero must pass the base clock through, so every base edge toggles
    wire prim_any = prim_sync_reg[1] ^ prim_last_reg;
    wire sys_any = sys_sync_reg[1] ^ sys_last_reg;
    wire undivided = (refout_divisor == 4'h0);
    wire prim_base = undivided ? prim_any : prim_edge;
    wire sys_base = undivided ? sys_any : sys_edge;
    wire base_tick = refout_source_select ? prim_base : sys_base;

    // sleep needs both bits since the system clock stops in sleep
    wire sleep_ok = refout_run_in_sleep && refout_source_select;
    // no oscillator mode is checked here, so run stays high in sleep even while primary_osc_power is low
    assign run = refout_output_enable && (!sleeping || sleep_ok);

    assign primary_osc_power = !sleeping || primary_mode || primary_osc_keep_alive;

    wire div_out;

    rco_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .run(run),
        .base_tick(base_tick),
        .div_code(refout_divisor),
        .clk_out(div_out)
    );

    // pin driven low while stopped, only divided clock when running
    assign refout_pin = run & div_out;
    assign refout_pin_oe = refout_output_enable;

endmodule

`default_nettype wire

// >>> hdl/rco_defs.vh
`ifndef RCO_DEFS_VH
`define RCO_DEFS_VH

// register byte addresses on the apb slave
`define RCO_ADDR_CTRL 12'h000
`define RCO_ADDR_STATUS 12'h004
`define RCO_ADDR_SYS 12'h008

// control register field positions
`define RCO_BIT_EN 15
`define RCO_BIT_SLP 13
`define RCO_BIT_SEL 12
`define RCO_DIV_HI 11
`define RCO_DIV_LO 8

// implemented bits of the control register and its reset value
`define RCO_CTRL_MASK 16'hbf00
`define RCO_CTRL_RESET 16'h0000

// system configuration register bit positions
`define RCO_SYS_KEEP 0
`define RCO_SYS_PRIM_MODE 1

`endif

// >>> hdl/rco_divider.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// power-of-two divider running on the selected base clock tick
// ****************************************************************
module rco_divider (
    input wire clk,
    input wire rst_n,
    input wire run,
    input wire base_tick,
    input wire [3:0] div_code,
    output reg clk_out
);

    reg [14:0] count_reg;

    // count ticks; toggle output when the count hits half the period
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 15'h0000;
            clk_out <= 1'b0;
        end else if (!run) begin
            // restart from a known low state so re-enable starts cleanly
            count_reg <= 15'h0000;
            clk_out <= 1'b0;
        end else if (base_tick) begin
            if (div_code == 4'h0) begin
                // undivided: the tick marks both base edges, so the pin copies the base
                clk_out <= ~clk_out;
            end else if (count_reg >= ((15'h0001 << (div_code - 4'h1)) - 15'h0001)) begin
                count_reg <= 15'h0000;
                clk_out <= ~clk_out;
            end else begin
                count_reg <= count_reg + 15'h0001;
            end
        end
    end

endmodule

`default_nettype wire

// >>> bench/rco_refout_props.sv
`timescale 1ns/1ps
`default_nettype none
// pin watcher; a shadow of control writes stands in for the hidden register
module rco_refout_chk (
    input wire clk, rst_n, psel, penable, pwrite, pready, pslverr, sleep_mode,
    input wire refout_pin, refout_pin_oe, primary_osc_power,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata
);
    logic [7:0] c_reg;
    wire acc = psel && penable && paddr == 12'h000;
    // dead bits masked so the shadow reads back like the real register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) c_reg <= 8'h00;
        else if (acc && pwrite) c_reg <= pwdata[15:8] & 8'hbf;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // six edges cover the two-stage sleep synchroniser
    sequence s_slept; sleep_mode [*6]; endsequence
    sequence s_rd; acc && !pwrite; endsequence
    chk_oe_follow: assert property (refout_pin_oe == c_reg[7]) else $error("oe off");
    chk_off_low: assert property (!refout_pin_oe |-> !refout_pin) else $error("pin up");
    chk_ctl_read: assert property (s_rd |-> prdata == {16'h0, c_reg, 8'h00})
        else $error("bad read");
    chk_rd_hold: assert property (psel && penable |=> $stable(prdata)) else $error("rd moved");
    chk_bad_addr: assert property (psel && penable && paddr > 12'h008 |-> pslverr)
        else $error("no error");
    chk_sleep_stop: assert property (s_slept ##0 c_reg[5:4] != 2'b11 |-> !refout_pin)
        else $error("runs in sleep");
    chk_awake_osc: assert property ((!sleep_mode) [*6] |-> primary_osc_power)
        else $error("osc off");
    chk_ready_up: assert property (pready) else $error("not ready");
endmodule
bind rco_refout rco_refout_chk u_chk (.*);
`default_nettype wire

// >>> bench/rco_ext_sink.sv
`timescale 1ns/1ps
`default_nettype none
// external load clocked by the pin alone; a disabled pin is not counted
module rco_ext_sink (input wire refout_pin, refout_pin_oe, clr, output logic [15:0] edges);
    always @(posedge refout_pin or posedge clr) begin
        if (clr) edges <= 16'h0000;
        else if (refout_pin_oe) edges <= edges + 16'h0001;
    end
endmodule
`default_nettype wire

// >>> bench/rco_refout_test.sv
`timescale 1ns/1ps
`default_nettype none
module rco_refout_test;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic sleep_mode = 0, clr = 0, primary_osc_tick = 0, sys_clk_tick = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [3:0] pstrb = 4'hf;
    logic [7:0] v;
    wire pready, pslverr, refout_pin, refout_pin_oe, primary_osc_power;
    wire [31:0] prdata;
    wire [15:0] edges;
    int error_cnt = 0, check_count = 0, seed = 32'h3f89d06b, p = 0, q = 0, h = 7;
    rco_refout DUT (.*);
    rco_ext_sink u_sink (.*);
    initial forever #2 clk = ~clk;
    // two free base clocks, each slower than clk/4 as the inputs demand
    always @(posedge clk) begin
        p <= (p == 4) ? 0 : p + 1;
        q <= (q >= h - 1) ? 0 : q + 1;
        if (p == 4) primary_osc_tick <= ~primary_osc_tick;
        if (q >= h - 1) sys_clk_tick <= ~sys_clk_tick;
    end
    task check(input logic [31:0] seen, input logic [31:0] e, input string what);
        check_count++;
        error_cnt += (seen !== e);
        if (seen !== e) $display("[FAIL] %s expected %h seen %h", what, e, seen);
    endtask
    task finish_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // spare edge first, so a released psel never rises again in the same step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk) penable <= 1;
        do @(posedge clk) n++; while (pready !== 1'b1 && n < 20);
        error_cnt += (n == 20);
        if (n == 20) finish_test;
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    function automatic logic [31:0] ctl_exp(input logic [7:0] c);
        return {16'h0, c & 8'hbf, 8'h00};
    endfunction
    // eight pin periods give eight pin edges, none while the pin is stopped
    task freq(input logic [3:0] d, input int hp, input logic on);
        repeat (8) @(posedge clk);
        clr <= 1;
        @(posedge clk) clr <= 0;
        repeat ((16 * hp) << d) @(posedge clk);
        check(32'(on ? (edges > 6 && edges < 10) : edges == 0), 1, "edges");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        apb(0, 0, 0);
        check(rd, 0, "reset");
        for (int c = 0; c < 16; c++) begin
            v = 8'($random(seed)) & 8'hf0 | 8'(c);
            apb(1, 0, $random(seed) & 32'hffff00ff | {16'h0, v, 8'h00});
            apb(0, 0, 0);
            check(rd, ctl_exp(v), "control");
        end
        // the system clock changes rate every run; it is the base in the even runs, the primary tick in the odd ones
        for (int i = 0; i < 6; i++) begin
            h <= 3 + i;
            v = {3'b100, 1'(i), (i < 2) ? 4'(i) : 4'($random(seed) & 3)};
            apb(1, 0, {16'h0, v, 8'h00});
            freq(v[3:0], v[4] ? 5 : 3 + i, 1);
        end
        apb(1, 12'h008, 1);
        for (int k = 0; k < 3; k++) begin
            sleep_mode <= 0;
            apb(1, 0, (k == 0) ? 32'hb000 : (k == 1) ? 32'h9000 : 32'ha000);
            sleep_mode <= 1;
            freq(0, 5, k == 0);
        end
        apb(1, 12'h008, 0);
        repeat (8) @(posedge clk);
        check(32'(primary_osc_power), 0, "osc power");
        sleep_mode <= 0;
        apb(0, 12'h00c, 0);
        check(32'(pslverr), 1, "slverr");
        finish_test;
    end
endmodule
`default_nettype wire
